/* File: shared/ecs_consts.vh */
// Constants for the enclave segmentation and paging check block
`ifndef ECS_CONSTS_VH
`define ECS_CONSTS_VH
// Register byte offsets
`define ECS_REG_CTRL 8'h00
`define ECS_REG_BMAP_LO 8'h04
`define ECS_REG_BMAP_HI 8'h08
`define ECS_REG_CMD 8'h0C
`define ECS_REG_STATUS 8'h10
`define ECS_REG_OPND_LO 8'h14
`define ECS_REG_OPND_HI 8'h18
`define ECS_REG_DS_BASE 8'h1C
`define ECS_REG_LIN_LO 8'h20
`define ECS_REG_LIN_HI 8'h24
`define ECS_REG_FS_OFS 8'h28
`define ECS_REG_FS_LIMF 8'h2C
`define ECS_REG_GS_OFS 8'h30
`define ECS_REG_GS_LIMF 8'h34
`define ECS_REG_ENCL_BASE 8'h38
`define ECS_REG_FS_BASE 8'h3C
`define ECS_REG_FS_LIM 8'h40
`define ECS_REG_GS_BASE 8'h44
`define ECS_REG_GS_LIM 8'h48
`define ECS_REG_SEG_ATTR 8'h4C
// Control register bits
`define ECS_CTRL_FEAT_EN 0
`define ECS_CTRL_FEAT_LOCK 1
`define ECS_CTRL_PAGING 2
`define ECS_CTRL_GUEST 3
`define ECS_CTRL_SEXIT 4
`define ECS_CTRL_APICV 5
`define ECS_CTRL_WIDE 6
`define ECS_CTRL_W 7
`define ECS_CTRL_RST 7'h00
// Command word fields
`define ECS_CMD_LEAF 7:0
`define ECS_CMD_OP 10:8
`define ECS_CMD_OPSIZE 11
`define ECS_CMD_ADRSIZE 12
`define ECS_CMD_SEGOVR 13
`define ECS_CMD_CPL 15:14
`define ECS_CMD_CSMODE 17:16
`define ECS_CMD_DS_USABLE 18
`define ECS_CMD_DS_EXPDN 19
`define ECS_CMD_SUBSET_OK 20
`define ECS_CMD_GS_SEL 21
`define ECS_CMD_APIC_OVL 22
`define ECS_CMD_ACC 24:23
`define ECS_CMD_IN_RANGE 25
// Command operation kinds
`define ECS_OP_USER 3'h0
`define ECS_OP_SUPER 3'h1
`define ECS_OP_SEG_WRITE 3'h2
`define ECS_OP_BASE_WRITE 3'h3
`define ECS_OP_ASYNC_EXIT 3'h4
`define ECS_OP_ACCESS 3'h5
`define ECS_OP_FETCH 3'h6
// Memory access kinds
`define ECS_ACC_NONE 2'h0
`define ECS_ACC_IMPLICIT 2'h1
`define ECS_ACC_EXPLICIT 2'h2
`define ECS_ACC_NONENCL 2'h3
// Code segment modes
`define ECS_CS_16 2'h0
`define ECS_CS_32 2'h1
`define ECS_CS_64 2'h2
// Leaf numbers
`define ECS_LEAF_ENTER 8'h02
`define ECS_LEAF_RESUME 8'h03
`define ECS_LEAF_EXIT 8'h04
`define ECS_LEAF_DBG_RD 8'h04
`define ECS_LEAF_DBG_WR 8'h05
`define ECS_CPL_USER 2'h3
`define ECS_CPL_SUPER 2'h0
// Outcome codes
`define ECS_RES_OK 3'h0
`define ECS_RES_UD 3'h1
`define ECS_RES_GP 3'h2
`define ECS_RES_PF 3'h3
`define ECS_RES_VMX_LEAF 3'h4
`define ECS_RES_VMX_APIC 3'h5
`endif

/* File: src/ecs_exit_bitmap.v */
// Supervisor leaf exiting bitmap lookup
`timescale 1ns/100ps
module ecs_exit_bitmap #(
    parameter LEAVES = 64
) (
    input wire [LEAVES-1:0] bitmap,
    input wire [7:0] leaf,
    input wire exit_ctrl,
    input wire guest,
    output wire vm_exit
);
    wire [LEAVES-1:0] hit;
    genvar i;
    generate
        for (i = 0; i < LEAVES; i = i + 1) begin : g_bit
            localparam [7:0] IDX = i;
            assign hit[i] = bitmap[i] & (leaf == IDX);
        end
    endgenerate
    // Leaf numbers beyond the bitmap never exit
    assign vm_exit = guest & exit_ctrl & (|hit);
endmodule // ecs_exit_bitmap

/* File: src/ecs_save_slot.v */
// Hidden save slot for segment register state
`timescale 1ns/100ps
module ecs_save_slot #(
    parameter W = 64
) (
    input wire clk,
    input wire rst_n,
    input wire save,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= {W{1'b0}};
        end else if (save) begin
            dout <= din;
        end
    end
endmodule // ecs_save_slot

/* File: src/ecs_top.v */
// Enclave segmentation, paging and virtualization check unit
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ecs_consts.vh"
module ecs_top #(
    parameter LEAVES = 64
) (
    input wire REF_CLK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    output reg EVENT_VALID,
    output reg [2:0] EVENT_CODE,
    output reg IN_ENCLAVE,
    output reg ADDR_WIDE,
    output reg PAGE_CHECK,
    output reg AD_UPDATE_OK
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    reg rst_meta;
    reg rst_n;
    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle per access
    wire req = AVS_READ | AVS_WRITE;
    wire wr_commit = AVS_WRITE & ~AVS_WAITREQUEST;
    wire rd_load = AVS_READ & AVS_WAITREQUEST;
    wire wr_cmd = wr_commit & (AVS_ADDRESS == `ECS_REG_CMD);

    reg [`ECS_CTRL_W-1:0] ctrl;
    reg [LEAVES-1:0] bmap;
    reg [63:0] opnd;
    reg [31:0] ds_base;
    reg [63:0] lin;
    reg [31:0] fs_ofs;
    reg [31:0] fs_limf;
    reg [31:0] gs_ofs;
    reg [31:0] gs_limf;
    reg [31:0] encl_base;
    reg [31:0] fs_base;
    reg [31:0] fs_lim;
    reg [31:0] gs_base;
    reg [31:0] gs_lim;
    reg [31:0] seg_attr;
    reg [2:0] last_res;
    reg in_encl;
    reg [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    wire [7:0] c_leaf = AVS_WRITEDATA[`ECS_CMD_LEAF];
    wire [2:0] c_op = AVS_WRITEDATA[`ECS_CMD_OP];
    wire [1:0] c_cpl = AVS_WRITEDATA[`ECS_CMD_CPL];
    wire [1:0] c_mode = AVS_WRITEDATA[`ECS_CMD_CSMODE];
    wire [1:0] c_acc = AVS_WRITEDATA[`ECS_CMD_ACC];
    wire c_apic = AVS_WRITEDATA[`ECS_CMD_APIC_OVL];
    wire c_super = (c_op == `ECS_OP_SUPER);
    wire c_insn = (c_op == `ECS_OP_USER) | c_super;
    wire c_wide = (c_mode == `ECS_CS_64);
    wire feat_ok = ctrl[`ECS_CTRL_FEAT_EN] & ctrl[`ECS_CTRL_FEAT_LOCK];
    wire paging = ctrl[`ECS_CTRL_PAGING];
    wire apicv = ctrl[`ECS_CTRL_APICV] & ctrl[`ECS_CTRL_GUEST];
    wire wide_attr = ctrl[`ECS_CTRL_WIDE];
    wire is_dbg = c_super & ((c_leaf == `ECS_LEAF_DBG_RD) | (c_leaf == `ECS_LEAF_DBG_WR));
    wire is_enter = ~c_super & (c_leaf == `ECS_LEAF_ENTER);
    wire is_resume = ~c_super & (c_leaf == `ECS_LEAF_RESUME);
    wire is_exit = ~c_super & (c_leaf == `ECS_LEAF_EXIT);
    wire is_entry = is_enter | is_resume;
    wire bmap_exit;

    ecs_exit_bitmap #(
        .LEAVES(LEAVES)
    ) u_bitmap (
        .bitmap(bmap),
        .leaf(c_leaf),
        .exit_ctrl(ctrl[`ECS_CTRL_SEXIT]),
        .guest(ctrl[`ECS_CTRL_GUEST]),
        .vm_exit(bmap_exit)
    );

    // Entry consistency: subset, code mode, privilege, not nested
    wire entry_bad = ~AVS_WRITEDATA[`ECS_CMD_SUBSET_OK] |
        (c_wide != wide_attr) | (c_cpl != `ECS_CPL_USER) | in_encl;

    // Outcome of APIC-access page overlap for a data access
    reg [2:0] apic_res;
    always @* begin
        apic_res = `ECS_RES_OK;
        if (apicv & c_apic) begin
            case (c_acc)
                `ECS_ACC_EXPLICIT: apic_res = `ECS_RES_PF;
                `ECS_ACC_NONENCL: apic_res = `ECS_RES_VMX_APIC;
                default: apic_res = `ECS_RES_OK;
            endcase
        end
    end

    // Single outcome in fixed priority
    reg [2:0] res;
    always @* begin
        res = `ECS_RES_OK;
        case (c_op)
            `ECS_OP_USER, `ECS_OP_SUPER: begin
                if (!feat_ok) begin
                    res = `ECS_RES_UD;
                end else if (AVS_WRITEDATA[`ECS_CMD_OPSIZE]) begin
                    res = `ECS_RES_UD;
                end else if (!paging && !is_dbg) begin
                    res = `ECS_RES_UD;
                end else if (c_super && (c_cpl != `ECS_CPL_SUPER)) begin
                    res = `ECS_RES_GP;
                end else if (c_super && bmap_exit) begin
                    res = `ECS_RES_VMX_LEAF;
                end else if (!AVS_WRITEDATA[`ECS_CMD_DS_USABLE]
                        || AVS_WRITEDATA[`ECS_CMD_DS_EXPDN]) begin
                    res = `ECS_RES_GP;
                end else if (is_entry && entry_bad) begin
                    res = `ECS_RES_GP;
                end else if (is_exit && !in_encl) begin
                    res = `ECS_RES_GP;
                end else begin
                    res = apic_res;
                end
            end
            `ECS_OP_SEG_WRITE: res = in_encl ? `ECS_RES_UD : `ECS_RES_OK;
            `ECS_OP_BASE_WRITE: begin
                res = (in_encl && !wide_attr) ? `ECS_RES_UD : `ECS_RES_OK;
            end
            `ECS_OP_ACCESS: res = apic_res;
            `ECS_OP_FETCH: begin
                if (in_encl && !AVS_WRITEDATA[`ECS_CMD_IN_RANGE]) begin
                    res = `ECS_RES_GP;
                end
            end
            default: begin
                res = `ECS_RES_OK;
            end
        endcase
    end

    wire ok = (res == `ECS_RES_OK);
    wire do_enter = wr_cmd & ok & (c_op == `ECS_OP_USER) & is_enter;
    wire do_resume = wr_cmd & ok & (c_op == `ECS_OP_USER) & is_resume;
    wire do_exit = wr_cmd & ok & (c_op == `ECS_OP_USER) & is_exit;
    wire do_aex = wr_cmd & (c_op == `ECS_OP_ASYNC_EXIT) & in_encl;
    wire do_bwr = wr_cmd & ok & (c_op == `ECS_OP_BASE_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // Saved segment state: host copy and state save frame copy
    wire [159:0] host_saved;
    wire [63:0] frame_saved;

    ecs_save_slot #(
        .W(160)
    ) u_host_slot (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .save(do_enter | do_resume),
        .din({seg_attr, gs_lim, gs_base, fs_lim, fs_base}),
        .dout(host_saved)
    );

    ecs_save_slot #(
        .W(64)
    ) u_frame_slot (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .save(do_aex),
        .din({gs_base, fs_base}),
        .dout(frame_saved)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Linear address: always data segment, width from mode only
    wire [63:0] eff_ofs = c_wide ? opnd : {32'h0000_0000, opnd[31:0]};
    wire [63:0] sum = {32'h0000_0000, ds_base} + eff_ofs;
    wire [63:0] next_lin = c_wide ? sum : {32'h0000_0000, sum[31:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Register file and segment state
    wire seg_sw = wr_commit & ~in_encl;
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `ECS_CTRL_RST;
            bmap <= {LEAVES{1'b0}};
            opnd <= 64'h0000_0000_0000_0000;
            ds_base <= 32'h0000_0000;
            lin <= 64'h0000_0000_0000_0000;
            fs_ofs <= 32'h0000_0000;
            fs_limf <= 32'h0000_0000;
            gs_ofs <= 32'h0000_0000;
            gs_limf <= 32'h0000_0000;
            encl_base <= 32'h0000_0000;
            fs_base <= 32'h0000_0000;
            fs_lim <= 32'h0000_0000;
            gs_base <= 32'h0000_0000;
            gs_lim <= 32'h0000_0000;
            seg_attr <= 32'h0000_0000;
            last_res <= `ECS_RES_OK;
            in_encl <= 1'b0;
        end else begin
            if (wr_commit) begin
                case (AVS_ADDRESS)
                    `ECS_REG_CTRL: ctrl <= AVS_WRITEDATA[`ECS_CTRL_W-1:0];
                    `ECS_REG_BMAP_LO: bmap[31:0] <= AVS_WRITEDATA;
                    `ECS_REG_BMAP_HI: bmap[63:32] <= AVS_WRITEDATA;
                    `ECS_REG_OPND_LO: opnd[31:0] <= AVS_WRITEDATA;
                    `ECS_REG_OPND_HI: opnd[63:32] <= AVS_WRITEDATA;
                    `ECS_REG_DS_BASE: ds_base <= AVS_WRITEDATA;
                    `ECS_REG_FS_OFS: fs_ofs <= AVS_WRITEDATA;
                    `ECS_REG_FS_LIMF: fs_limf <= AVS_WRITEDATA;
                    `ECS_REG_GS_OFS: gs_ofs <= AVS_WRITEDATA;
                    `ECS_REG_GS_LIMF: gs_limf <= AVS_WRITEDATA;
                    `ECS_REG_ENCL_BASE: encl_base <= AVS_WRITEDATA;
                    default: begin
                    end
                endcase
            end
            if (wr_cmd) begin
                last_res <= res;
                if (c_insn) begin
                    lin <= next_lin;
                end
            end
            // Live segment state; register writes only outside the enclave
            if (do_enter) begin
                fs_base <= fs_ofs + encl_base;
                fs_lim <= fs_limf;
                gs_base <= gs_ofs + encl_base;
                gs_lim <= gs_limf;
                in_encl <= 1'b1;
            end else if (do_resume) begin
                fs_base <= frame_saved[31:0];
                fs_lim <= fs_limf;
                gs_base <= frame_saved[63:32];
                gs_lim <= gs_limf;
                in_encl <= 1'b1;
            end else if (do_exit || do_aex) begin
                fs_base <= host_saved[31:0];
                fs_lim <= host_saved[63:32];
                gs_base <= host_saved[95:64];
                gs_lim <= host_saved[127:96];
                seg_attr <= host_saved[159:128];
                in_encl <= 1'b0;
            end else if (do_bwr) begin
                if (AVS_WRITEDATA[`ECS_CMD_GS_SEL]) begin
                    gs_base <= opnd[31:0];
                end else begin
                    fs_base <= opnd[31:0];
                end
            end else if (seg_sw) begin
                case (AVS_ADDRESS)
                    `ECS_REG_FS_BASE: fs_base <= AVS_WRITEDATA;
                    `ECS_REG_FS_LIM: fs_lim <= AVS_WRITEDATA;
                    `ECS_REG_GS_BASE: gs_base <= AVS_WRITEDATA;
                    `ECS_REG_GS_LIM: gs_lim <= AVS_WRITEDATA;
                    `ECS_REG_SEG_ATTR: seg_attr <= AVS_WRITEDATA;
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped reads return zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (AVS_ADDRESS)
            `ECS_REG_CTRL: next_rdata = {25'h0, ctrl};
            `ECS_REG_BMAP_LO: next_rdata = bmap[31:0];
            `ECS_REG_BMAP_HI: next_rdata = bmap[63:32];
            `ECS_REG_STATUS: next_rdata = {26'h0, ADDR_WIDE, in_encl, 1'b0, last_res};
            `ECS_REG_OPND_LO: next_rdata = opnd[31:0];
            `ECS_REG_OPND_HI: next_rdata = opnd[63:32];
            `ECS_REG_DS_BASE: next_rdata = ds_base;
            `ECS_REG_LIN_LO: next_rdata = lin[31:0];
            `ECS_REG_LIN_HI: next_rdata = lin[63:32];
            `ECS_REG_FS_OFS: next_rdata = fs_ofs;
            `ECS_REG_FS_LIMF: next_rdata = fs_limf;
            `ECS_REG_GS_OFS: next_rdata = gs_ofs;
            `ECS_REG_GS_LIMF: next_rdata = gs_limf;
            `ECS_REG_ENCL_BASE: next_rdata = encl_base;
            `ECS_REG_FS_BASE: next_rdata = fs_base;
            `ECS_REG_FS_LIM: next_rdata = fs_lim;
            `ECS_REG_GS_BASE: next_rdata = gs_base;
            `ECS_REG_GS_LIM: next_rdata = gs_lim;
            `ECS_REG_SEG_ATTR: next_rdata = seg_attr;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs and event outputs
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
            EVENT_VALID <= 1'b0;
            EVENT_CODE <= `ECS_RES_OK;
            IN_ENCLAVE <= 1'b0;
            ADDR_WIDE <= 1'b0;
            PAGE_CHECK <= 1'b0;
            AD_UPDATE_OK <= 1'b0;
        end else begin
            AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
            if (rd_load) begin
                AVS_READDATA <= next_rdata;
            end
            EVENT_VALID <= wr_cmd;
            if (wr_cmd) begin
                EVENT_CODE <= res;
                ADDR_WIDE <= c_wide;
            end
            IN_ENCLAVE <= (do_enter | do_resume) ? 1'b1 :
                ((do_exit | do_aex) ? 1'b0 : IN_ENCLAVE);
            // Operand addresses go to the page walker when paging is on
            PAGE_CHECK <= wr_cmd & c_insn & paging & feat_ok
                & ~AVS_WRITEDATA[`ECS_CMD_OPSIZE];
            // Non-faulting protected accesses may mark accessed/dirty
            AD_UPDATE_OK <= wr_cmd & paging & ((c_acc == `ECS_ACC_IMPLICIT)
                | ((c_acc == `ECS_ACC_EXPLICIT) & ~(apicv & c_apic)));
        end
    end
endmodule // ecs_top

/* File: verification/ecs_top_assertions.sv */
// Port-level assertions for the enclave check unit
`timescale 1ns/100ps
`include "ecs_consts.vh"
module ecs_top_assertions #(
    parameter LEAVES = 64
) (
    input wire REF_CLK,
    input wire RESET_N,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    input wire EVENT_VALID,
    input wire [2:0] EVENT_CODE,
    input wire IN_ENCLAVE,
    input wire ADDR_WIDE,
    input wire PAGE_CHECK,
    input wire AD_UPDATE_OK
);
reg [6:0] ctl;
wire wc = AVS_WRITE && !AVS_WAITREQUEST;
wire cmt = wc && AVS_ADDRESS == `ECS_REG_CMD;
wire [2:0] op = AVS_WRITEDATA[10:8];
wire en = ctl[1:0] == 2'h3;
wire usr = cmt && op == `ECS_OP_USER && en && !AVS_WRITEDATA[11];
// Mirror of the control register as committed
always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        ctl <= 7'h00;
    end else if (wc && AVS_ADDRESS == `ECS_REG_CTRL) begin
        ctl <= AVS_WRITEDATA[6:0];
    end
end
default clocking cb @(posedge REF_CLK); endclocking
default disable iff (!RESET_N);
AST_EVENT_AFTER_CMD: assert property (cmt |=> EVENT_VALID)
    else $error("no event after command");
AST_EVENT_CAUSE: assert property (EVENT_VALID |-> $past(cmt) && !$past(EVENT_VALID))
    else $error("event without command");
AST_FEATURE_UD: assert property (cmt && op < 3'h2 && !en |=> EVENT_CODE == `ECS_RES_UD)
    else $error("feature off not refused");
AST_OPSIZE_UD: assert property (cmt && op < 3'h2 && en && AVS_WRITEDATA[11] |=>
    EVENT_CODE == `ECS_RES_UD) else $error("operand size prefix not refused");
AST_PAGING_UD: assert property (usr && !ctl[2] |=> EVENT_CODE == `ECS_RES_UD)
    else $error("paging off not refused");
AST_DS_GP: assert property (usr && ctl[2] && !AVS_WRITEDATA[18] |=>
    EVENT_CODE == `ECS_RES_GP) else $error("unusable data segment accepted");
AST_SEG_UD: assert property (cmt && op == `ECS_OP_SEG_WRITE && IN_ENCLAVE |=>
    EVENT_CODE == `ECS_RES_UD && IN_ENCLAVE) else $error("segment change inside");
AST_PAGE_PULSE: assert property (PAGE_CHECK |-> EVENT_VALID)
    else $error("paging check without event");
AST_AD_PULSE: assert property (AD_UPDATE_OK |-> EVENT_VALID)
    else $error("flag update without event");
COV_LEAF_EXIT: cover property (EVENT_VALID && EVENT_CODE == `ECS_RES_VMX_LEAF);
COV_APIC_EXIT: cover property (EVENT_VALID && EVENT_CODE == `ECS_RES_VMX_APIC);
COV_ENTER: cover property ($rose(IN_ENCLAVE));
endmodule // ecs_top_assertions
bind ecs_top ecs_top_assertions #(.LEAVES(LEAVES)) ecs_top_assertions_inst (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EVENT_VALID(EVENT_VALID), .EVENT_CODE(EVENT_CODE),
    .IN_ENCLAVE(IN_ENCLAVE), .ADDR_WIDE(ADDR_WIDE), .PAGE_CHECK(PAGE_CHECK),
    .AD_UPDATE_OK(AD_UPDATE_OK));

/* File: verification/ecs_top_tb.sv */
// Self-checking bench for the enclave check unit
`timescale 1ns/100ps
`include "ecs_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
$display("BAD %0t got %h want %h", $time, a, b); end end
module ecs_top_tb;
reg REF_CLK = 1'b0;
reg RESET_N = 1'b0;
reg AVS_READ = 1'b0;
reg AVS_WRITE = 1'b0;
reg [7:0] AVS_ADDRESS = 8'h00;
reg [31:0] AVS_WRITEDATA = 32'h0;
wire [31:0] AVS_READDATA;
wire AVS_WAITREQUEST, EVENT_VALID, IN_ENCLAVE, ADDR_WIDE, PAGE_CHECK, AD_UPDATE_OK;
wire [2:0] EVENT_CODE;
int fail_count = 0;
int tests_run = 0;
int cyc = 0;
int i;
reg [31:0] d;
reg [47:0] r;
// Control byte, command word, outcome nibble, flag-update and width flags
reg [47:0] rows [0:28] = '{
48'h050004C00010, 48'h060004C00010, 48'h070004C80010, 48'h030004C00010, 48'h030004010400,
48'h030004010500, 48'h030004010010, 48'h070004F00002, 48'h070005F00002, 48'h070006F00003,
48'h070000C00020, 48'h07000CC00020, 48'h070000010020, 48'h1F0004010040, 48'h1F0004013F40,
48'h1F0004010100, 48'h0F0004010000, 48'h170004010000, 48'h1F0004C10020, 48'h1F0000010040,
48'h2F0144C50030, 48'h2F01C4C50050, 48'h2F00C4C50004, 48'h0F0144C50004, 48'h470015C00220,
48'h470016000220, 48'h470006C00220, 48'h070016C00220, 48'h070004C00420};
ecs_top #(.LEAVES(64)) ecs_top_inst (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EVENT_VALID(EVENT_VALID), .EVENT_CODE(EVENT_CODE),
    .IN_ENCLAVE(IN_ENCLAVE), .ADDR_WIDE(ADDR_WIDE), .PAGE_CHECK(PAGE_CHECK),
    .AD_UPDATE_OK(AD_UPDATE_OK));
initial forever #4 REF_CLK = ~REF_CLK;
always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 6000) begin
        fail_count++;
        print_verdict;
    end
end
task print_verdict;
    $display("tests %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
// Request held until waitrequest is sampled low
task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= v;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
    d = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
endtask
task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
endtask
task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(d, e)
endtask
task cmd(input logic [31:0] c, input logic [2:0] e);
    wr(8'h0C, c);
    // Event pulses stand only in the cycle after the commit edge
    #1;
    `CHK(EVENT_VALID, 1'b1)
    `CHK(EVENT_CODE, e)
endtask
initial begin
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    #1;
    `CHK(AVS_WAITREQUEST, 1'b1)
    rc(8'h00, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'hFC, 32'h0);
    wr(8'h04, 32'h00000001);
    wr(8'h08, 32'h80000000);
    for (i = 0; i < 29; i++) begin
        r = rows[i];
        wr(8'h00, {24'h0, r[47:40]});
        cmd(r[39:8], r[6:4]);
        `CHK(IN_ENCLAVE, 1'b0)
        if (r[1]) `CHK(ADDR_WIDE, r[0])
        `CHK(AD_UPDATE_OK, r[2])
    end
    $display("table done");
    wr(8'h1C, 32'hFFFFFFF0);
    wr(8'h14, 32'h20);
    wr(8'h18, 32'h1);
    cmd(32'h0004C000, 3'h0);
    `CHK(PAGE_CHECK, 1'b1)
    rc(8'h20, 32'h10);
    rc(8'h24, 32'h0);
    cmd(32'h0006C000, 3'h0);
    rc(8'h24, 32'h2);
    $display("address done");
    wr(8'h00, 32'h47);
    wr(8'h28, 32'h100);
    wr(8'h30, 32'h200);
    wr(8'h2C, 32'hFFF);
    wr(8'h38, 32'h10000);
    wr(8'h3C, 32'hAAAA);
    wr(8'h4C, 32'h33);
    cmd(32'h0016C002, 3'h0);
    `CHK(IN_ENCLAVE, 1'b1)
    rc(8'h3C, 32'h10100);
    rc(8'h40, 32'hFFF);
    rc(8'h44, 32'h10200);
    wr(8'h3C, 32'h1234);
    rc(8'h3C, 32'h10100);
    cmd(32'h00000200, `ECS_RES_UD);
    wr(8'h14, 32'h5000);
    cmd(32'h00000300, `ECS_RES_OK);
    rc(8'h3C, 32'h5000);
    cmd(32'h00000600, `ECS_RES_GP);
    cmd(32'h02000600, `ECS_RES_OK);
    cmd(32'h00000400, `ECS_RES_OK);
    `CHK(IN_ENCLAVE, 1'b0)
    rc(8'h3C, 32'hAAAA);
    rc(8'h4C, 32'h33);
    cmd(32'h0016C003, 3'h0);
    rc(8'h3C, 32'h5000);
    cmd(32'h0016C004, 3'h0);
    rc(8'h3C, 32'hAAAA);
    $display("enclave done");
    cmd(32'h0016C002, 3'h0);
    `CHK(IN_ENCLAVE, 1'b1)
    @(posedge REF_CLK);
    RESET_N <= 1'b0;
    @(posedge REF_CLK);
    #1;
    `CHK(IN_ENCLAVE, 1'b0)
    `CHK(AVS_WAITREQUEST, 1'b1)
    @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    rc(8'h00, 32'h0);
    rc(8'h3C, 32'h0);
    $display("reset done");
    print_verdict;
end
endmodule // ecs_top_tb
